// ==== hdl/gpi_params.svh ====
`ifndef GPI_PARAMS_SVH
`define GPI_PARAMS_SVH
`define GPI_PORTS 3
`define GPI_WIDTH 16
`define GPI_OFS_DATA 6'h00
`define GPI_OFS_CLR 6'h04
`define GPI_OFS_SET 6'h08
`define GPI_OFS_TOG 6'h0C
`define GPI_OFS_DIR 6'h10
`define GPI_OFS_INEN 6'h14
`define GPI_OFS_MSET 6'h18
`define GPI_OFS_MCLR 6'h1C
`define GPI_OFS_EDGE 6'h20
`define GPI_OFS_BOTH 6'h24
`define GPI_OFS_STAT 6'h28
`define GPI_OFS_PEND 6'h2C
`define GPI_OFS_FUNC 6'h30
`define GPI_RST_WORD 32'h0000_0000
`endif

// ==== hdl/gpi_pkg.sv ====
`default_nettype none
// Types shared by the port bank.
package gpi_pkg;
    // Register selected by a byte offset inside one port.
    typedef enum {
        gpi_r_data, gpi_r_clr, gpi_r_set, gpi_r_tog, gpi_r_dir,
        gpi_r_inen, gpi_r_mset, gpi_r_mclr, gpi_r_edge, gpi_r_both,
        gpi_r_stat, gpi_r_pend, gpi_r_func, gpi_r_none
    } gpi_reg_type;
endpackage
`default_nettype wire

// ==== hdl/gpi_ports.sv ====
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`include "gpi_params.svh"
`default_nettype none
// Three port modules of general-purpose pins behind one APB slave.
module gpi_ports #(
    parameter int PORTS = `GPI_PORTS,
    parameter int WIDTH = `GPI_WIDTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PORTS*WIDTH-1:0] pin_in,
    input wire logic [PORTS*WIDTH-1:0] periph_out,
    input wire logic [PORTS*WIDTH-1:0] periph_drive,
    output logic [PORTS*WIDTH-1:0] pin_out,
    output logic [PORTS*WIDTH-1:0] pin_oe_n,
    output logic [PORTS*WIDTH-1:0] periph_in,
    output logic [PORTS-1:0] irq
);
    localparam int N = PORTS * WIDTH;

    // Default clocking for the checks below.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Maps a byte offset within a port to its register.
    function automatic gpi_pkg::gpi_reg_type reg_of(input logic [5:0] a);
        case (a)
            `GPI_OFS_DATA: reg_of = gpi_pkg::gpi_r_data;
            `GPI_OFS_CLR: reg_of = gpi_pkg::gpi_r_clr;
            `GPI_OFS_SET: reg_of = gpi_pkg::gpi_r_set;
            `GPI_OFS_TOG: reg_of = gpi_pkg::gpi_r_tog;
            `GPI_OFS_DIR: reg_of = gpi_pkg::gpi_r_dir;
            `GPI_OFS_INEN: reg_of = gpi_pkg::gpi_r_inen;
            `GPI_OFS_MSET: reg_of = gpi_pkg::gpi_r_mset;
            `GPI_OFS_MCLR: reg_of = gpi_pkg::gpi_r_mclr;
            `GPI_OFS_EDGE: reg_of = gpi_pkg::gpi_r_edge;
            `GPI_OFS_BOTH: reg_of = gpi_pkg::gpi_r_both;
            `GPI_OFS_STAT: reg_of = gpi_pkg::gpi_r_stat;
            `GPI_OFS_PEND: reg_of = gpi_pkg::gpi_r_pend;
            `GPI_OFS_FUNC: reg_of = gpi_pkg::gpi_r_func;
            default: reg_of = gpi_pkg::gpi_r_none;
        endcase
    endfunction

    logic pready_ff; // Access-phase answer strobe.
    logic [31:0] prdata_ff; // Captured read word.
    logic pslverr_ff; // Error answer for unmapped words.
    logic [N-1:0] data_ff; // Output values written by software.
    logic [N-1:0] dir_ff; // One makes the pin an output.
    logic [N-1:0] inen_ff; // One enables the input buffer.
    logic [N-1:0] func_ff; // One hands the pin to a peripheral.
    logic [N-1:0] en_ff; // Interrupt enables.
    logic [N-1:0] edge_ff; // One selects edge sensitivity.
    logic [N-1:0] both_ff; // One counts falling edges too.
    logic [N-1:0] pend_ff; // Pending edge events.
    logic [N-1:0] sync1_ff; // First synchroniser stage.
    logic [N-1:0] sync2_ff; // Second synchroniser stage.
    logic [N-1:0] prev_ff; // Interrupt source one cycle ago.
    logic [N-1:0] pin_out_ff; // Registered pin value.
    logic [N-1:0] pin_oe_n_ff; // Registered pin enable, low drives.
    logic [N-1:0] periph_in_ff; // Registered pin level to peripherals.
    logic [PORTS-1:0] irq_ff; // Registered request per port.

    // Bus decode terms.
    logic [1:0] port_idx;
    logic port_ok;
    gpi_pkg::gpi_reg_type rsel;
    logic wr;
    logic [N-1:0] pm;
    logic [N-1:0] wf;
    logic [N-1:0] wbits;
    logic [N-1:0] sense;
    logic [N-1:0] src;
    logic [N-1:0] ev;
    logic [N-1:0] nxt_data;
    logic [N-1:0] nxt_pend;
    logic [N-1:0] req;

    assign port_idx = paddr[7:6];
    assign port_ok = 32'(port_idx) < PORTS;
    assign rsel = reg_of(paddr[5:0]);
    // A write takes effect at the edge where the answer is sampled.
    assign wr = psel & penable & pready_ff & pwrite & port_ok;
    // Write data copied into every port slice.
    assign wf = {PORTS{pwdata[WIDTH-1:0]}};
    assign wbits = wf & pm;

    genvar gp;
    generate
        for (gp = 0; gp < PORTS; gp++) begin : g_port
            // Selects the slice of the addressed port.
            assign pm[gp*WIDTH +: WIDTH] = {WIDTH{32'(port_idx) == gp}};
            // Combines level and pending requests into one line.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    irq_ff[gp] <= 1'b0;
                end else begin
                    irq_ff[gp] <= |req[gp*WIDTH +: WIDTH];
                end
            end
        end
    endgenerate

    // Answers each access after one wait cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= psel & penable & ~pready_ff;
        end
    end

    // Captures read data and error at the edge that raises the answer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= `GPI_RST_WORD;
            pslverr_ff <= 1'b0;
        end else if (psel & penable & ~pready_ff) begin
            pslverr_ff <= ~port_ok | (rsel == gpi_pkg::gpi_r_none);
            prdata_ff <= `GPI_RST_WORD;
            if (port_ok) begin
                case (rsel)
                    gpi_pkg::gpi_r_data: prdata_ff[WIDTH-1:0] <= data_ff[port_idx*WIDTH +: WIDTH];
                    gpi_pkg::gpi_r_set: prdata_ff[WIDTH-1:0] <= data_ff[port_idx*WIDTH +: WIDTH];
                    gpi_pkg::gpi_r_clr: prdata_ff[WIDTH-1:0] <= data_ff[port_idx*WIDTH +: WIDTH];
                    gpi_pkg::gpi_r_tog: prdata_ff[WIDTH-1:0] <= data_ff[port_idx*WIDTH +: WIDTH];
                    gpi_pkg::gpi_r_dir: prdata_ff[WIDTH-1:0] <= dir_ff[port_idx*WIDTH +: WIDTH];
                    gpi_pkg::gpi_r_inen: prdata_ff[WIDTH-1:0] <= inen_ff[port_idx*WIDTH +: WIDTH];
                    gpi_pkg::gpi_r_mset: prdata_ff[WIDTH-1:0] <= en_ff[port_idx*WIDTH +: WIDTH];
                    gpi_pkg::gpi_r_mclr: prdata_ff[WIDTH-1:0] <= en_ff[port_idx*WIDTH +: WIDTH];
                    gpi_pkg::gpi_r_edge: prdata_ff[WIDTH-1:0] <= edge_ff[port_idx*WIDTH +: WIDTH];
                    gpi_pkg::gpi_r_both: prdata_ff[WIDTH-1:0] <= both_ff[port_idx*WIDTH +: WIDTH];
                    gpi_pkg::gpi_r_stat: prdata_ff[WIDTH-1:0] <= sense[port_idx*WIDTH +: WIDTH];
                    gpi_pkg::gpi_r_pend: prdata_ff[WIDTH-1:0] <= pend_ff[port_idx*WIDTH +: WIDTH];
                    gpi_pkg::gpi_r_func: prdata_ff[WIDTH-1:0] <= func_ff[port_idx*WIDTH +: WIDTH];
                    default: prdata_ff <= `GPI_RST_WORD;
                endcase
            end
        end
    end

    // Computes the next output values from the four modify registers.
    always_comb begin
        nxt_data = data_ff;
        if (wr) begin
            case (rsel)
                gpi_pkg::gpi_r_data: nxt_data = (data_ff & ~pm) | wbits;
                gpi_pkg::gpi_r_set: nxt_data = data_ff | wbits;
                gpi_pkg::gpi_r_clr: nxt_data = data_ff & ~wbits;
                gpi_pkg::gpi_r_tog: nxt_data = data_ff ^ wbits;
                default: nxt_data = data_ff;
            endcase
        end
    end

    // Holds the output values.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_ff <= '0;
        end else begin
            data_ff <= nxt_data;
        end
    end

    // Holds direction, input buffer and function selects.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_ff <= '0;
            inen_ff <= '0;
            func_ff <= '0;
        end else if (wr) begin
            if (rsel == gpi_pkg::gpi_r_dir) begin
                dir_ff <= (dir_ff & ~pm) | wbits;
            end
            // The input buffer is enabled per pin.
            if (rsel == gpi_pkg::gpi_r_inen) begin
                inen_ff <= (inen_ff & ~pm) | wbits;
            end
            // The function select is loaded per pin.
            if (rsel == gpi_pkg::gpi_r_func) begin
                func_ff <= (func_ff & ~pm) | wbits;
            end
        end
    end

    // Holds interrupt enables and sensitivity selects.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff <= '0;
            edge_ff <= '0;
            both_ff <= '0;
        end else if (wr) begin
            if (rsel == gpi_pkg::gpi_r_mset) begin
                en_ff <= en_ff | wbits;
            end
            if (rsel == gpi_pkg::gpi_r_mclr) begin
                en_ff <= en_ff & ~wbits;
            end
            if (rsel == gpi_pkg::gpi_r_edge) begin
                edge_ff <= (edge_ff & ~pm) | wbits;
            end
            if (rsel == gpi_pkg::gpi_r_both) begin
                both_ff <= (both_ff & ~pm) | wbits;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
        end
    end

    // A disabled input buffer senses zero.
    assign sense = sync2_ff & inen_ff;
    assign src = (dir_ff & data_ff) | (~dir_ff & sense);
    assign ev = edge_ff & ((src & ~prev_ff) | (both_ff & ~src & prev_ff));

    // Pending events clear by writing one; a new event wins.
    always_comb begin
        nxt_pend = pend_ff;
        if (wr && rsel == gpi_pkg::gpi_r_pend) begin
            nxt_pend = pend_ff & ~wbits;
        end
        nxt_pend = nxt_pend | ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_ff <= '0;
            prev_ff <= '0;
        end else begin
            pend_ff <= nxt_pend;
            prev_ff <= src;
        end
    end

    assign req = en_ff & ((~edge_ff & src) | (edge_ff & pend_ff));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_ff <= '0;
            pin_oe_n_ff <= '1;
            periph_in_ff <= '0;
        end else begin
            pin_out_ff <= (func_ff & periph_out) | (~func_ff & data_ff);
            pin_oe_n_ff <= ~((func_ff & periph_drive) | (~func_ff & dir_ff));
            periph_in_ff <= sync2_ff;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign pin_out = pin_out_ff;
    assign pin_oe_n = pin_oe_n_ff;
    assign periph_in = periph_in_ff;
    assign irq = irq_ff;

    // Checks on the port bank.
    // single answer strobe
    ready_pulse_a: assert property (pready_ff |=> !pready_ff)
        else $error("answer strobe held two cycles");
    set_bits_a: assert property (wr && rsel == gpi_pkg::gpi_r_set
        |=> data_ff == ($past(data_ff) | $past(wbits)))
        else $error("set write wrong");
    clr_bits_a: assert property (wr && rsel == gpi_pkg::gpi_r_clr
        |=> data_ff == ($past(data_ff) & ~$past(wbits)))
        else $error("clear write wrong");
    tog_bits_a: assert property (wr && rsel == gpi_pkg::gpi_r_tog
        |=> data_ff == ($past(data_ff) ^ $past(wbits)))
        else $error("toggle write wrong");
    data_load_a: assert property (wr && rsel == gpi_pkg::gpi_r_data
        |=> (data_ff & $past(pm)) == $past(wbits))
        else $error("data load wrong");
    dir_keep_a: assert property (wr && rsel == gpi_pkg::gpi_r_dir
        |=> (dir_ff & ~$past(pm)) == ($past(dir_ff) & ~$past(pm)))
        else $error("direction of another port changed");
    dir_drive_a: assert property (##1 (pin_oe_n_ff
        == ~(($past(func_ff) & $past(periph_drive)) | (~$past(func_ff) & $past(dir_ff)))))
        else $error("pin enable wrong");
    pin_mux_a: assert property (##1 (pin_out_ff
        == (($past(func_ff) & $past(periph_out)) | (~$past(func_ff) & $past(data_ff)))))
        else $error("pin value wrong");
    periph_route_a: assert property (##1 (periph_in_ff == $past(sync2_ff)))
        else $error("peripheral input wrong");
    func_load_a: assert property (wr && rsel == gpi_pkg::gpi_r_func
        |=> (func_ff & $past(pm)) == $past(wbits))
        else $error("function select wrong");
    port3_err_a: assert property (psel && penable && !pready_ff && !port_ok
        |=> pslverr_ff && prdata_ff == '0)
        else $error("unmapped port not refused");
    en_set_a: assert property (wr && rsel == gpi_pkg::gpi_r_mset
        |=> en_ff == ($past(en_ff) | $past(wbits)))
        else $error("enable set wrong");
    en_clr_a: assert property (wr && rsel == gpi_pkg::gpi_r_mclr
        |=> en_ff == ($past(en_ff) & ~$past(wbits)))
        else $error("enable clear wrong");
    en_keep_a: assert property (!(wr && (rsel == gpi_pkg::gpi_r_mset
        || rsel == gpi_pkg::gpi_r_mclr)) |=> en_ff == $past(en_ff))
        else $error("enables changed without write");
    rise_pend_a: assert property (
        ##1 ((~pend_ff & $past(edge_ff & src & ~prev_ff)) == '0))
        else $error("rising edge not pending");
    fall_only_a: assert property (
        ##1 ((pend_ff & ~$past(pend_ff) & $past(~both_ff & prev_ff & ~src)) == '0))
        else $error("falling edge pending without both");
    fall_both_a: assert property (
        ##1 ((~pend_ff & $past(edge_ff & both_ff & prev_ff & ~src)) == '0))
        else $error("falling edge not pending");
    pend_hold_a: assert property (!(wr && rsel == gpi_pkg::gpi_r_pend)
        |=> (pend_ff & $past(pend_ff)) == $past(pend_ff))
        else $error("pending dropped without clear");
    irq_level_a: assert property (
        |(en_ff[WIDTH-1:0] & ~edge_ff[WIDTH-1:0] & src[WIDTH-1:0]) |=> irq_ff[0])
        else $error("level request missing");
    sync_lat_a: assert property (##2 (sync2_ff == $past(pin_in, 2)))
        else $error("synchroniser latency wrong");

endmodule // gpi_ports
`default_nettype wire

// ==== test/gpi_pin_model.sv ====
`default_nettype none
// Far side of the pins: a driven pin reads back its own value.
module gpi_pin_model (
    input wire logic [47:0] pin_out,
    input wire logic [47:0] pin_oe_n,
    input wire logic [47:0] ext_level,
    output logic [47:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released pins follow the outside level set by the bench.
    assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule // gpi_pin_model
`default_nettype wire

// ==== test/gpi_ports_tb.sv ====
`include "gpi_params.svh"
`default_nettype none
// Register-level bench for the three port modules.
module gpi_ports_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr;
    logic [47:0] pin_in, periph_out, periph_drive, pin_out, pin_oe_n, periph_in, ext;
    logic [2:0] irq;
    int err_count = 0;
    int n_tests = 0;
    gpi_ports u_gpi_ports (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .periph_out(periph_out),
        .periph_drive(periph_drive), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .periph_in(periph_in), .irq(irq));
    gpi_pin_model u_gpi_pin_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .ext_level(ext), .pin_in(pin_in));
    // Clock of 5 ns period.
    initial begin
        forever #2.5 pclk = ~pclk;
    end
    // Prints the counts and the verdict, then stops.
    task automatic complete_run;
        $display("Checks %0d, errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Compares one value and counts a mismatch.
    task automatic chk(input string nm, input logic [47:0] ex, input logic [47:0] got);
        n_tests++;
        if (got !== ex) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // One APB transfer, held until pready is sampled high.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (pready !== 1'b1) begin
            chk("pready", 48'h1, 48'h0);
            complete_run();
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [7:0] ad(input int p, input logic [5:0] o);
        return {2'(p), o};
    endfunction
    task automatic wr(input int p, input logic [5:0] o, input logic [15:0] d);
        logic [31:0] rd;
        logic e;
        xfer(1'b1, ad(p, o), {16'h0000, d}, rd, e);
    endtask
    // Reads a word and checks data and error flag together.
    task automatic rdc(input string nm, input logic [7:0] a, input logic [15:0] ex,
                       input logic er);
        logic [31:0] rd;
        logic e;
        xfer(1'b0, a, 32'h0000_0000, rd, e);
        chk(nm, {15'h0000, er, 16'h0000, ex}, {15'h0000, e, rd});
    endtask
    // Waits a bounded time for one request line to reach a level.
    task automatic wirq(input int p, input logic v);
        int n;
        n = 0;
        while (irq[p] !== v && n < 10) begin
            n++;
            @(posedge pclk);
        end
        chk("irq", {47'h0, v}, {47'h0, irq[p]});
        if (irq[p] !== v) begin
            complete_run();
        end
    endtask
    // Main sequence.
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ext = 48'h0;
        periph_out = 48'h0;
        periph_drive = 48'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk("pin_oe_n", 48'hFFFF_FFFF_FFFF, pin_oe_n);
        chk("irq", 48'h0, {45'h0, irq});
        rdc("func", ad(0, `GPI_OFS_FUNC), 16'h0000, 1'b0);
        rdc("stat", ad(1, `GPI_OFS_STAT), 16'h0000, 1'b0);
        wr(0, `GPI_OFS_DATA, 16'hA5A5);
        wr(0, `GPI_OFS_DIR, 16'hFFFF);
        // The registered driver enable trails the direction write by one edge.
        repeat (2) @(posedge pclk);
        chk("pin_out", 48'h0000_0000_A5A5, pin_out);
        chk("pin_oe_n", 48'hFFFF_FFFF_0000, pin_oe_n);
        wr(0, `GPI_OFS_SET, 16'h000F);
        rdc("set", ad(0, `GPI_OFS_DATA), 16'hA5AF, 1'b0);
        wr(0, `GPI_OFS_CLR, 16'h00F0);
        rdc("clr", ad(0, `GPI_OFS_DATA), 16'hA50F, 1'b0);
        wr(0, `GPI_OFS_TOG, 16'hFF00);
        rdc("tog", ad(0, `GPI_OFS_DATA), 16'h5A0F, 1'b0);
        wr(0, `GPI_OFS_INEN, 16'hFFFF);
        rdc("stat0", ad(0, `GPI_OFS_STAT), 16'h5A0F, 1'b0);
        wr(0, `GPI_OFS_MSET, 16'h0010);
        wr(0, `GPI_OFS_SET, 16'h0010);
        wirq(0, 1'b1);
        wr(0, `GPI_OFS_MCLR, 16'h0010);
        wirq(0, 1'b0);
        wr(1, `GPI_OFS_INEN, 16'hFFFF);
        ext[31:16] <= 16'h1234;
        rdc("stat1", ad(1, `GPI_OFS_STAT), 16'h1234, 1'b0);
        chk("periph_in", {32'h0000_0000, 16'h1234}, {32'h0000_0000, periph_in[31:16]});
        wr(1, `GPI_OFS_EDGE, 16'h0001);
        wr(1, `GPI_OFS_MSET, 16'h0001);
        ext[16] <= 1'b1;
        wirq(1, 1'b1);
        wr(1, `GPI_OFS_PEND, 16'h0001);
        wirq(1, 1'b0);
        ext[16] <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("irq1", 48'h0, {47'h0, irq[1]});
        wr(1, `GPI_OFS_BOTH, 16'h0001);
        ext[16] <= 1'b1;
        wirq(1, 1'b1);
        wr(1, `GPI_OFS_PEND, 16'h0001);
        ext[16] <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("irq1", 48'h1, {47'h0, irq[1]});
        wr(2, `GPI_OFS_INEN, 16'h0001);
        wr(2, `GPI_OFS_MSET, 16'h0001);
        ext[32] <= 1'b1;
        wirq(2, 1'b1);
        ext[32] <= 1'b0;
        wirq(2, 1'b0);
        wr(2, `GPI_OFS_FUNC, 16'h0002);
        periph_drive[33] <= 1'b1;
        periph_out[33] <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("periph", 48'h1, {46'h0, pin_oe_n[33], pin_out[33]});
        rdc("port3", 8'hC0, 16'h0000, 1'b1);
        rdc("gap", ad(0, 6'h34), 16'h0000, 1'b1);
        complete_run();
    end
endmodule // gpi_ports_tb
`default_nettype wire
